/* pkg/lvd_cfg.svh */
// register map, field positions, reset values and timing counts
`ifndef LVD_CFG_SVH
`define LVD_CFG_SVH

`define LVD_ADDR_W 4
`define LVD_ADDR_CTRL 4'h0
`define LVD_ADDR_STAT 4'h4
`define LVD_ADDR_MASK 4'h8
`define LVD_ADDR_COUNT 4'hc

`define LVD_CTRL_EN 0
`define LVD_CTRL_SRC 2:1
`define LVD_CTRL_THR 6:3
`define LVD_CTRL_HYST 7
`define LVD_CTRL_FLEN 10:8
`define LVD_CTRL_LVL 11
`define LVD_CTRL_FALL 12
`define LVD_CTRL_RISE 13
`define LVD_CTRL_ACT 14
`define LVD_CTRL_W 15
`define LVD_CTRL_RST 15'h0000

`define LVD_STAT_INT 0
`define LVD_STAT_RSTF 1
`define LVD_STAT_LVL 2
`define LVD_STAT_RAW 3
`define LVD_FLAG_W 2
`define LVD_FLAG_RST 2'h0
`define LVD_MASK_RST 2'h0

`define LVD_CNT_W 8

`define LVD_CLK_MHZ 250
`define LVD_TICK_NS 1000
`define LVD_TICK_CYC ((`LVD_TICK_NS * `LVD_CLK_MHZ) / 1000)
`define LVD_SETTLE_NS 2000
`define LVD_SETTLE_CYC ((`LVD_SETTLE_NS * `LVD_CLK_MHZ + 999) / 1000)
`define LVD_TIMER_W 10

`endif

/* pkg/lvd_pkg.sv */
// types shared by the detector modules
package lvd_pkg;
    typedef enum logic [1:0] {
        SRC_SUPPLY,
        SRC_PIN_A,
        SRC_PIN_B,
        SRC_PIN_C
    } src_sel_t;

    typedef enum logic {
        ACT_IRQ,
        ACT_RESET
    } action_t;

    typedef enum {
        ST_OFF,
        ST_SETTLE,
        ST_RUN
    } mon_state_t;
endpackage

/* pkg/lvd_filt_if.sv */
// carrier between detector control and comparator filter
`timescale 1ns/100ps
interface lvd_filt_if;
    logic tick;
    logic raw;
    logic [2:0] len;
    logic clr;
    logic level;

    modport filt (input tick, input raw, input len, input clr, output level);
    modport ctrl (output tick, output raw, output len, output clr, input level);
endinterface

/* verilog/lvd_sync.sv */
// two flip-flop synchroniser for asynchronous levels
`timescale 1ns/100ps
module lvd_sync #(
    parameter int W = 1
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta_q <= '0;
            o_q <= '0;
        end else begin
            meta_q <= i_d;
            o_q <= meta_q;
        end
    end
endmodule

/* verilog/lvd_filter.sv */
// digital stability filter on the comparator result
`timescale 1ns/100ps
`include "lvd_cfg.svh"
module lvd_filter (
    input wire logic i_clk,
    input wire logic i_rst_b,
    lvd_filt_if.filt f
);
    logic [7:0] need;
    logic [7:0] cnt_q;
    logic lvl_q;

    assign need = 8'h01 << f.len;
    assign f.level = lvl_q;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_q <= 8'h00;
            lvl_q <= 1'b0;
        end else if (f.clr) begin
            cnt_q <= 8'h00;
            lvl_q <= f.raw;
        end else if (f.tick) begin
            if (f.raw == lvl_q) begin
                cnt_q <= 8'h00;
            end else if (cnt_q + 8'h01 >= need) begin
                cnt_q <= 8'h00;
                lvl_q <= f.raw;
            end else begin
                cnt_q <= cnt_q + 8'h01;
            end
        end
    end
endmodule

/* verilog/low_voltage_detector.sv */
// control, trigger and flag logic of the low voltage detector
//
// Operation
// - software selects one of four sources
// - sixteen-step threshold code drives reference
// - level trigger: event while below threshold
// - falling trigger: event on crossing below
// - rising trigger: event on returning above
// - triggers enabled independently, any combination
// - event sets the interrupt or the reset flag, never both
// - flags stay set until software clears
// - no new event until flag cleared
// - eight-step selectable comparator filter
// - runs in low power, interrupt wakes
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`include "lvd_cfg.svh"
module low_voltage_detector (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // register port
    input wire logic [`LVD_ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // analog comparator side
    input wire logic i_cmp_below,
    output logic o_analog_en,
    output logic [1:0] o_src_sel,
    output logic [3:0] o_thresh_code,
    output logic o_hyst_en,
    // system side
    output logic o_irq,
    output logic o_reset_req
);
    logic rst_meta_q;
    logic rst_sync_q;
    logic rst_b;
    logic [`LVD_CTRL_W-1:0] ctrl_q;
    logic [`LVD_FLAG_W-1:0] flag_q;
    logic [`LVD_FLAG_W-1:0] mask_q;
    logic [`LVD_CNT_W-1:0] count_q;
    logic [`LVD_TIMER_W-1:0] tick_cnt_q;
    logic tick_q;
    logic [`LVD_TIMER_W-1:0] settle_q;
    lvd_pkg::mon_state_t state_q;
    logic cmp_sync;
    logic prev_q;
    logic below;
    logic running;
    logic ev_level;
    logic ev_fall;
    logic ev_rise;
    logic event_hit;
    logic [`LVD_FLAG_W-1:0] flag_set;
    logic [`LVD_FLAG_W-1:0] flag_clr;
    logic cfg_change;
    logic [31:0] rdata_d;
    lvd_pkg::action_t act;

    lvd_filt_if filt_bus ();

    // reset release through two flip-flops
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end
    assign rst_b = rst_sync_q;

    lvd_sync #(.W(1)) u_cmp_sync (
        .i_clk(i_clk),
        .i_rst_b(rst_b),
        .i_d(i_cmp_below),
        .o_q(cmp_sync)
    );

    // control register
    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= `LVD_CTRL_RST;
        end else if (i_wr && i_addr == `LVD_ADDR_CTRL) begin
            ctrl_q <= i_wdata[`LVD_CTRL_W-1:0];
        end
    end

    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            mask_q <= `LVD_MASK_RST;
        end else if (i_wr && i_addr == `LVD_ADDR_MASK) begin
            mask_q <= i_wdata[`LVD_FLAG_W-1:0];
        end
    end

    // analog controls straight from the control register
    // source select
    assign o_src_sel = ctrl_q[`LVD_CTRL_SRC];
    assign o_thresh_code = ctrl_q[`LVD_CTRL_THR];
    assign o_hyst_en = ctrl_q[`LVD_CTRL_HYST];
    assign o_analog_en = ctrl_q[`LVD_CTRL_EN];
    assign act = lvd_pkg::action_t'(ctrl_q[`LVD_CTRL_ACT]);

    // analog path changes need a settle time before judging
    assign cfg_change = i_wr && i_addr == `LVD_ADDR_CTRL &&
        (i_wdata[`LVD_CTRL_SRC] != ctrl_q[`LVD_CTRL_SRC] ||
         i_wdata[`LVD_CTRL_THR] != ctrl_q[`LVD_CTRL_THR] ||
         i_wdata[`LVD_CTRL_HYST] != ctrl_q[`LVD_CTRL_HYST] ||
         i_wdata[`LVD_CTRL_EN] != ctrl_q[`LVD_CTRL_EN]);

    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= lvd_pkg::ST_OFF;
            settle_q <= '0;
        end else begin
            unique case (state_q)
                lvd_pkg::ST_OFF: begin
                    if (ctrl_q[`LVD_CTRL_EN]) begin
                        state_q <= lvd_pkg::ST_SETTLE;
                        settle_q <= `LVD_TIMER_W'(`LVD_SETTLE_CYC - 1);
                    end
                end
                lvd_pkg::ST_SETTLE: begin
                    if (!ctrl_q[`LVD_CTRL_EN]) begin
                        state_q <= lvd_pkg::ST_OFF;
                    end else if (cfg_change) begin
                        settle_q <= `LVD_TIMER_W'(`LVD_SETTLE_CYC - 1);
                    end else if (settle_q == '0) begin
                        state_q <= lvd_pkg::ST_RUN;
                    end else begin
                        settle_q <= settle_q - `LVD_TIMER_W'(1);
                    end
                end
                lvd_pkg::ST_RUN: begin
                    if (!ctrl_q[`LVD_CTRL_EN]) begin
                        state_q <= lvd_pkg::ST_OFF;
                    end else if (cfg_change) begin
                        state_q <= lvd_pkg::ST_SETTLE;
                        settle_q <= `LVD_TIMER_W'(`LVD_SETTLE_CYC - 1);
                    end
                end
            endcase
        end
    end
    assign running = state_q == lvd_pkg::ST_RUN;

    // filter sample tick divider
    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            tick_cnt_q <= '0;
            tick_q <= 1'b0;
        end else if (tick_cnt_q == `LVD_TIMER_W'(`LVD_TICK_CYC - 1)) begin
            tick_cnt_q <= '0;
            tick_q <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + `LVD_TIMER_W'(1);
            tick_q <= 1'b0;
        end
    end

    assign filt_bus.tick = tick_q;
    assign filt_bus.raw = cmp_sync;
    assign filt_bus.len = ctrl_q[`LVD_CTRL_FLEN];
    assign filt_bus.clr = !running;
    assign below = filt_bus.level;

    lvd_filter u_filter (
        .i_clk(i_clk),
        .i_rst_b(rst_b),
        .f(filt_bus.filt)
    );

    // previous filtered level, restarted with the filter
    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            prev_q <= 1'b0;
        end else if (!running) begin
            prev_q <= cmp_sync;
        end else begin
            prev_q <= below;
        end
    end

    assign ev_level = ctrl_q[`LVD_CTRL_LVL] && below;
    assign ev_fall = ctrl_q[`LVD_CTRL_FALL] && below && !prev_q;
    assign ev_rise = ctrl_q[`LVD_CTRL_RISE] && !below && prev_q;
    assign event_hit = running && (ev_level || ev_fall || ev_rise);

    // no new event while a flag is up
    assign flag_set[`LVD_STAT_INT] = event_hit && act == lvd_pkg::ACT_IRQ &&
        flag_q == '0;
    assign flag_set[`LVD_STAT_RSTF] = event_hit && act == lvd_pkg::ACT_RESET &&
        flag_q == '0;
    assign flag_clr = (i_wr && i_addr == `LVD_ADDR_STAT) ?
        i_wdata[`LVD_FLAG_W-1:0] : '0;

    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            flag_q <= `LVD_FLAG_RST;
        end else begin
            flag_q <= (flag_q & ~flag_clr) | flag_set;
        end
    end

    // saturating count of accepted detections
    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            count_q <= '0;
        end else if (i_wr && i_addr == `LVD_ADDR_COUNT) begin
            count_q <= '0;
        end else if (flag_set != '0 && count_q != '1) begin
            count_q <= count_q + `LVD_CNT_W'(1);
        end
    end

    // level interrupt usable as wake source
    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            o_irq <= 1'b0;
            o_reset_req <= 1'b0;
        end else begin
            o_irq <= |(flag_q & mask_q);
            o_reset_req <= flag_q[`LVD_STAT_RSTF];
        end
    end

    always_comb begin
        rdata_d = 32'h0000_0000;
        unique case (i_addr)
            `LVD_ADDR_CTRL: rdata_d[`LVD_CTRL_W-1:0] = ctrl_q;
            `LVD_ADDR_STAT: begin
                rdata_d[`LVD_FLAG_W-1:0] = flag_q;
                rdata_d[`LVD_STAT_LVL] = below;
                rdata_d[`LVD_STAT_RAW] = cmp_sync;
            end
            `LVD_ADDR_MASK: rdata_d[`LVD_FLAG_W-1:0] = mask_q;
            `LVD_ADDR_COUNT: rdata_d[`LVD_CNT_W-1:0] = count_q;
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            o_rdata <= 32'h0000_0000;
        end else if (i_rd) begin
            o_rdata <= rdata_d;
        end else begin
            o_rdata <= 32'h0000_0000;
        end
    end
endmodule

/* bench/lvd_analog_model.sv */
// behavioural comparator and threshold ladder facing the detector
`timescale 1ns/100ps
module lvd_analog_model (
    // control from detector
    input wire logic i_clk,
    input wire logic i_en,
    input wire logic [1:0] i_src,
    input wire logic [3:0] i_thr,
    input wire logic i_hyst,
    // source levels in threshold steps, one nibble per source
    input wire logic [15:0] i_v,
    // result
    output logic o_below
);
    logic [3:0] lv;
    assign lv = i_v[i_src*4 +: 4];
    always_ff @(posedge i_clk) begin
        if (!i_en) begin
            o_below <= 1'b0;
        end else if (lv < i_thr) begin
            o_below <= 1'b1;
        end else if (!i_hyst || lv > i_thr) begin
            o_below <= 1'b0;
        end
    end
endmodule

/* bench/lvd_sva.sv */
// port checker for the detector top
`timescale 1ns/100ps
`include "lvd_cfg.svh"
module lvd_sva (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic [`LVD_ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic [1:0] o_src_sel,
    input wire logic [3:0] o_thresh_code,
    input wire logic o_hyst_en,
    input wire logic o_irq,
    input wire logic o_reset_req
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    logic [14:0] ctrl_q;
    logic wc;
    assign wc = i_wr && i_addr == `LVD_ADDR_CTRL;
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ctrl_q <= 15'h0000;
        end else if (wc) begin
            ctrl_q <= i_wdata[14:0];
        end
    end
    property p_src; wc |=> o_src_sel == $past(i_wdata[2:1]); endproperty
    a_src: assert property (p_src) else $error("source select not taken");
    property p_thr; wc |=> o_thresh_code == $past(i_wdata[6:3]); endproperty
    a_thr: assert property (p_thr) else $error("threshold not taken");
    property p_hyst; wc |=> o_hyst_en == $past(i_wdata[7]); endproperty
    a_hyst: assert property (p_hyst) else $error("hysteresis not taken");
    property p_hold; !wc |=> $stable(o_thresh_code) && $stable(o_src_sel); endproperty
    a_hold: assert property (p_hold) else $error("control moved without write");
    property p_rst_hold;
        $fell(o_reset_req) |-> $past(i_wr && i_addr == `LVD_ADDR_STAT && i_wdata[1], 2);
    endproperty
    a_rst_hold: assert property (p_rst_hold) else $error("reset flag dropped alone");
    property p_irq_hold;
        $fell(o_irq) |-> $past(i_wr && (i_addr == `LVD_ADDR_STAT || i_addr == `LVD_ADDR_MASK), 2);
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped alone");
    property p_act; $rose(o_reset_req) |-> ctrl_q[14]; endproperty
    a_act: assert property (p_act) else $error("reset request in interrupt mode");
    property p_rdctl;
        i_rd && i_addr == `LVD_ADDR_CTRL |=> o_rdata == {17'h00000, ctrl_q};
    endproperty
    a_rdctl: assert property (p_rdctl) else $error("control readback differs");
    property p_idle; !i_rd |=> o_rdata == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data outside read");
endmodule
bind low_voltage_detector lvd_sva u_sva (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_src_sel(o_src_sel),
    .o_thresh_code(o_thresh_code), .o_hyst_en(o_hyst_en), .o_irq(o_irq),
    .o_reset_req(o_reset_req));

/* bench/test_low_voltage_detector.sv */
// register-level testbench of the detector with comparator model
`timescale 1ns/100ps
`include "lvd_cfg.svh"
module test_low_voltage_detector;
    localparam logic [3:0] C = `LVD_ADDR_CTRL;
    localparam logic [3:0] S = `LVD_ADDR_STAT;
    localparam logic [3:0] M = `LVD_ADDR_MASK;
    localparam logic [3:0] N = `LVD_ADDR_COUNT;
    logic i_clk = 1'b0, i_rst_b = 1'b0, i_wr = 1'b0, i_rd = 1'b0, below;
    logic [3:0] i_addr = 4'h0;
    logic [31:0] i_wdata = 32'h0, o_rdata, d;
    logic [15:0] v = 16'hffff;
    logic o_analog_en, o_hyst_en, o_irq, o_reset_req;
    logic [1:0] o_src_sel;
    logic [3:0] o_thresh_code;
    int n_mismatch = 0, compares = 0, n;
    always #2 i_clk = ~i_clk;
    low_voltage_detector dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_cmp_below(below),
        .o_analog_en(o_analog_en), .o_src_sel(o_src_sel), .o_thresh_code(o_thresh_code),
        .o_hyst_en(o_hyst_en), .o_irq(o_irq), .o_reset_req(o_reset_req));
    lvd_analog_model u_ana (.i_clk(i_clk), .i_en(o_analog_en), .i_src(o_src_sel),
        .i_thr(o_thresh_code), .i_hyst(o_hyst_en), .i_v(v), .o_below(below));
    task results;
        if (n_mismatch == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            n_mismatch++;
            $display("wrong value at %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task wr(input logic [3:0] a, input logic [31:0] x);
        @(posedge i_clk); i_wr <= 1'b1; i_addr <= a; i_wdata <= x;
        @(posedge i_clk); i_wr <= 1'b0;
    endtask
    task rd(input logic [3:0] a);
        @(posedge i_clk); i_rd <= 1'b1; i_addr <= a;
        @(posedge i_clk); i_rd <= 1'b0;
        @(negedge i_clk); d = o_rdata;
    endtask
    task idle(input int k); repeat (k) @(negedge i_clk); endtask
    task setv(input logic [15:0] x); @(posedge i_clk); v <= x; endtask
    task wt(input int lim);
        n = 0;
        while (n < lim && (o_irq | o_reset_req) !== 1'b1) begin
            @(negedge i_clk); n++;
        end
        if (n >= lim) begin n_mismatch++; results; end
    endtask
    initial begin
        repeat (16) @(posedge i_clk);
        i_rst_b <= 1'b1;
        repeat (3) @(posedge i_clk);
        rd(C); chk(d, 32'h0);
        rd(S); chk(d & 32'h3, 32'h0);
        rd(M); chk(d, 32'h0);
        rd(N); chk(d, 32'h0);
        wr(4'h2, 32'hffff); rd(4'h2); chk(d, 32'h0);
        for (int s = 0; s < 4; s++) begin
            wr(C, 32'((s << 1) | (s * 5) << 3 | (s & 1) << 7)); idle(1);
            chk(o_src_sel, 32'(s));
            chk(o_thresh_code, 32'(s * 5));
            chk(o_hyst_en, 32'(s & 1));
        end
        wr(M, 32'h1); wr(C, 32'h841); idle(520);
        chk(o_analog_en, 32'h1);
        setv(16'hfff5); wt(800);
        chk(o_reset_req, 32'h0);
        rd(S); chk(d & 32'h7, 32'h5);
        wr(S, 32'h1); idle(3); chk(o_irq, 32'h1);
        wr(M, 32'h0); idle(2); chk(o_irq, 32'h0);
        wr(M, 32'h1); idle(2); chk(o_irq, 32'h1);
        setv(16'hffff); idle(800); chk(o_irq, 32'h1);
        wr(S, 32'h1); idle(600); chk(o_irq, 32'h0);
        rd(N); chk(d, 32'h2);
        wr(N, 32'h0); rd(N); chk(d, 32'h0);
        wr(C, 32'h5041); idle(520); setv(16'hfff5); wt(800);
        chk(o_irq, 32'h0);
        rd(S); chk(d & 32'h3, 32'h2);
        wr(S, 32'h2); idle(600); chk(o_reset_req, 32'h0);
        setv(16'hffff); idle(600); chk(o_reset_req, 32'h0);
        setv(16'hf5ff); wr(C, 32'h2045); idle(1100); chk(o_irq, 32'h0);
        setv(16'hffff); wt(800); rd(S); chk(d & 32'h3, 32'h1);
        wr(S, 32'h1); wr(C, 32'h0b41); idle(520);
        setv(16'hfff5); idle(750); setv(16'hffff); idle(2500);
        chk(o_irq, 32'h0);
        setv(16'hfff5); wt(3000); chk(32'(n >= 1750), 32'h1);
        results;
    end
endmodule
